//--- fpp_protect.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpp_map.svh"

module fpp_protect #(
  parameter int          ADDR_W    = 15,
  parameter logic [15:0] OP_CYCLES = `FPP_OP_CYCLES
) (
  // Clock and synchronous reset
  input  wire logic              core_clk,
  input  wire logic              nrst,
  // Special function register port
  input  wire logic              sfr_wr,
  input  wire logic [7:0]        sfr_addr,
  input  wire logic [7:0]        sfr_wdata,
  output logic      [7:0]        sfr_rdata,
  // Firmware MOVX write and code location
  input  wire logic              movx_wr,
  input  wire logic [ADDR_W-1:0] movx_addr,
  input  wire logic [7:0]        movx_data,
  input  wire logic [ADDR_W-1:0] exec_addr,
  input  wire logic              key_ok,
  // Supply monitor state
  input  wire logic              vmon_en,
  input  wire logic              vmon_rst_en,
  // Two-wire debug port requests
  input  wire logic              dbg_wr,
  input  wire logic              dbg_erase,
  input  wire logic              debug_full_device_erase,
  input  wire logic [ADDR_W-1:0] dbg_addr,
  input  wire logic [7:0]        dbg_data,
  // Lock byte value stored in flash
  input  wire logic [7:0]        lock_byte_nv,
  // Interrupts
  input  wire logic              irq_req,
  output logic                   irq_hold,
  // Flash engine commands
  output logic                   fl_write,
  output logic                   fl_page_erase,
  output logic                   fl_mass_erase,
  output logic      [ADDR_W-1:0] fl_addr,
  output logic      [7:0]        fl_data,
  output logic                   xram_wr,
  // Reset request and cause
  output logic                   flash_error_device_reset,
  output logic                   flash_fault_reset_flag
);

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [ADDR_W-1:0] LOCK_ADDR = {ADDR_W{1'b1}} - ADDR_W'(`FPP_PAGE_BYTES);
  localparam int PAGE_W = ADDR_W - `FPP_PAGE_SHIFT;

  logic                store_write_enable;
  logic                store_erase_enable;
  logic [7:0]          lock_eff;
  logic                lock_written;
  logic                pending_reset;
  logic [15:0]         op_cnt;
  fpp_pkg::fpp_state_t state;

  // Page number of a flash address
  function automatic logic [PAGE_W-1:0] page_of(input logic [ADDR_W-1:0] a);
    page_of = a[ADDR_W-1:`FPP_PAGE_SHIFT];
  endfunction : page_of

  // Locked test shared by firmware and debug checks
  function automatic logic is_locked(input logic [ADDR_W-1:0] a, input logic [7:0] lb);
    logic [7:0] n;
    n = ~lb;
    // Count compared at full byte width so large counts are never folded
    if (page_of(a) == page_of(LOCK_ADDR)) begin
      is_locked = (lb != `FPP_LOCK_ERASED);
    end else begin
      is_locked = (8'(page_of(a)) < n);
    end
  endfunction : is_locked

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the firmware and debug accesses
  logic fw_flash, fw_erase, lock_pg, tgt_locked, exec_locked, fw_bad, dbg_bad;
  always_comb begin
    fw_flash    = movx_wr && store_write_enable && state == fpp_pkg::FPP_IDLE;
    fw_erase    = fw_flash && store_erase_enable;
    lock_pg     = page_of(movx_addr) == page_of(LOCK_ADDR);
    tgt_locked  = is_locked(movx_addr, lock_eff);
    exec_locked = is_locked(exec_addr, lock_eff);
    fw_bad      = fw_flash && (!vmon_en || !vmon_rst_en
                  || (tgt_locked && !exec_locked)
                  || (fw_erase && lock_pg)
                  || (!fw_erase && movx_addr == LOCK_ADDR && lock_written));
    dbg_bad     = (dbg_wr || dbg_erase) && (is_locked(dbg_addr, lock_eff)
                  || (dbg_wr && dbg_addr == LOCK_ADDR && lock_written));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register; upper bits are not stored
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      store_write_enable <= 1'b0;
      store_erase_enable <= 1'b0;
    end else if (sfr_wr && sfr_addr == `FPP_PSC_ADDR) begin
      store_write_enable <= sfr_wdata[`FPP_PSC_WE_BIT];
      store_erase_enable <= sfr_wdata[`FPP_PSC_EE_BIT];
    end
  end

  // Read data, reserved bits zero
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sfr_rdata <= `FPP_PSC_RESET;
    end else if (sfr_addr == `FPP_PSC_ADDR) begin
      sfr_rdata <= {6'h00, store_erase_enable, store_write_enable};
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective lock captured only at reset, so a new lock byte waits a reset
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      lock_eff     <= `FPP_LOCK_ERASED;
      lock_written <= 1'b0;
    end else if (debug_full_device_erase) begin
      lock_eff     <= `FPP_LOCK_ERASED;
      lock_written <= 1'b0;
    end else if (state == fpp_pkg::FPP_DONE && op_cnt == 16'h0000) begin
      lock_eff     <= lock_byte_nv;
      lock_written <= (lock_byte_nv != `FPP_LOCK_ERASED);
    end else if (fw_flash && !fw_bad && movx_addr == LOCK_ADDR) begin
      lock_written <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Post-reset load uses DONE with zero count; busy flash op holds interrupts
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state  <= fpp_pkg::FPP_DONE;
      op_cnt <= 16'h0000;
    end else begin
      unique case (state)
        fpp_pkg::FPP_IDLE: begin
          if (fw_flash && !fw_bad) begin
            state  <= fpp_pkg::FPP_BUSY;
            op_cnt <= OP_CYCLES;
          end
        end
        fpp_pkg::FPP_BUSY: begin
          if (op_cnt == 16'h0001) begin
            state <= fpp_pkg::FPP_IDLE;
          end
          op_cnt <= op_cnt - 16'h0001;
        end
        fpp_pkg::FPP_DONE: begin
          state <= fpp_pkg::FPP_IDLE;
        end
      endcase
    end
  end

  // Interrupt hold while an operation runs
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      irq_hold <= 1'b0;
    end else begin
      irq_hold <= irq_req && ((fw_flash && !fw_bad) || state == fpp_pkg::FPP_BUSY
                  && op_cnt != 16'h0001);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash commands; a refused debug access simply issues nothing
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fl_write      <= 1'b0;
      fl_page_erase <= 1'b0;
      fl_mass_erase <= 1'b0;
      fl_addr       <= '0;
      fl_data       <= 8'h00;
      xram_wr       <= 1'b0;
    end else begin
      fl_write      <= (fw_flash && !fw_erase && !fw_bad)
                       || (dbg_wr && !dbg_bad);
      fl_page_erase <= (fw_erase && !fw_bad)
                       || (dbg_erase && !dbg_bad);
      fl_mass_erase <= debug_full_device_erase;
      fl_addr       <= fw_flash ? movx_addr : dbg_addr;
      fl_data       <= fw_flash ? movx_data : dbg_data;
      xram_wr       <= movx_wr && !store_write_enable;
    end
  end

  // Error reset pulse; the cause flag survives the reset it triggers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      flash_error_device_reset <= 1'b0;
      pending_reset            <= 1'b0;
    end else begin
      flash_error_device_reset <= fw_bad;
      pending_reset            <= fw_bad;
    end
  end

  // Sticky cause flag: set on error, cleared by a reset that had no error
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      flash_fault_reset_flag <= pending_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The error pulse pulls reset low at once, so bad_resets_a, cause_flag_a and vmon_gate_a gate on nrst instead of disabling
  bad_resets_a: assert property (@(posedge core_clk)
    nrst && fw_bad |=> flash_error_device_reset) else $error("fault no reset");
  cause_flag_a: assert property (@(posedge core_clk)
    !nrst && pending_reset |=> flash_fault_reset_flag) else $error("cause lost");
  dbg_quiet_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (dbg_bad && !fw_bad) |=> !flash_error_device_reset)
    else $error("debug reset");
  mass_unlock_a: assert property (@(posedge core_clk) disable iff (!nrst)
    debug_full_device_erase |=> lock_eff == `FPP_LOCK_ERASED && fl_mass_erase)
    else $error("no unlock");
  vmon_gate_a: assert property (@(posedge core_clk)
    nrst && fw_flash && !(vmon_en && vmon_rst_en)
    |=> flash_error_device_reset && !fl_write && !fl_page_erase)
    else $error("vmon write");
  erase_both_a: assert property (@(posedge core_clk) disable iff (!nrst)
    fl_page_erase && !$past(dbg_erase) |-> $past(store_erase_enable && store_write_enable))
    else $error("bad erase");
  ctl_read_a: assert property (@(posedge core_clk) disable iff (!nrst)
    sfr_rdata[7:2] == 6'h00) else $error("reserved set");
  xram_route_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (movx_wr && store_write_enable) |=> !xram_wr) else $error("xram hit");
  lock_held_a: assert property (@(posedge core_clk) disable iff (!nrst)
    !debug_full_device_erase && state != fpp_pkg::FPP_DONE |=> $stable(lock_eff))
    else $error("lock moved");

endmodule : fpp_protect
`default_nettype wire

//--- fpp_map.svh
`ifndef FPP_MAP_SVH
`define FPP_MAP_SVH
// Special function register address of the program store control register
`define FPP_PSC_ADDR      8'h8f
// Field positions inside the program store control register
`define FPP_PSC_WE_BIT    0
`define FPP_PSC_EE_BIT    1
// Reset value of the program store control register
`define FPP_PSC_RESET     8'h00
// Page size and the bit where the page number starts in a flash address
`define FPP_PAGE_BYTES    512
`define FPP_PAGE_SHIFT    9
// Erased value of the lock byte: nothing locked
`define FPP_LOCK_ERASED   8'hff
// Cycles a flash write or erase keeps the engine busy (shortened default)
`define FPP_OP_CYCLES     16'h0010
`endif

//--- fpp_pkg.sv
package fpp_pkg;
  // Flash engine states, one-hot
  typedef enum logic [2:0] {
    FPP_IDLE  = 3'b001,
    FPP_BUSY  = 3'b010,
    FPP_DONE  = 3'b100
  } fpp_state_t;
endpackage : fpp_pkg

//--- fpp_fw_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Firmware and debug adapter, one request at a time
module fpp_fw_model (
  // Clock
  input  wire logic        core_clk,
  // Register and MOVX requests
  output logic             sfr_wr,
  output logic [7:0]       sfr_addr,
  output logic [7:0]       sfr_wdata,
  output logic             movx_wr,
  output logic [14:0]      movx_addr,
  output logic [7:0]       movx_data,
  output logic             key_ok,
  // Debug adapter requests
  output logic             dbg_wr,
  output logic             dbg_erase,
  output logic             debug_full_device_erase
);
  // Quiet at time zero
  initial begin
    {sfr_wr, movx_wr, key_ok, dbg_wr, dbg_erase, debug_full_device_erase} = '0;
    {sfr_addr, sfr_wdata, movx_addr, movx_data} = '0;
  end
  // Kind 0 register write, 1 MOVX, 2 debug write, 3 debug page erase, 4 debug mass erase;
  // any other kind only points the register address
  task automatic req(input int kind, input logic [14:0] a, input logic [7:0] d);
    @(posedge core_clk);
    key_ok <= 1'b1; // Key pair written ahead of every request
    @(posedge core_clk);
    {sfr_addr, sfr_wdata, movx_addr, movx_data} <= {a[7:0], d, a, d};
    {debug_full_device_erase, dbg_erase, dbg_wr, movx_wr, sfr_wr} <= 5'(1 << kind);
    @(posedge core_clk);
    {debug_full_device_erase, dbg_erase, dbg_wr, movx_wr, sfr_wr, key_ok} <= '0;
    // Released data lines must not keep the last value
    {sfr_wdata, movx_data} <= {~d, ~d};
  endtask : req
endmodule : fpp_fw_model
`default_nettype wire

//--- flash_program_protection_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module flash_program_protection_tb_top;
  // Bench-owned clock, reset and levels
  logic        core_clk = 1'b0;
  logic        sys_nrst = 1'b0;
  logic        vmon_en = 1'b1;
  logic        vmon_rst_en = 1'b1;
  logic        irq_req = 1'b0;
  logic [14:0] exec_addr = 15'h1000;
  logic [7:0]  lock_byte_nv = 8'hff;
  int          n_fail = 0;
  int          cmp_count = 0;
  // Nets between model and block
  logic        sfr_wr, movx_wr, key_ok, dbg_wr, dbg_erase, debug_full_device_erase;
  logic        irq_hold, fl_write, fl_page_erase, fl_mass_erase, xram_wr, err_rst, fault;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, movx_data, fl_data;
  logic [14:0] movx_addr, fl_addr;
  // An error request pulls the device reset, as the reset generator would
  wire         nrst = sys_nrst & ~err_rst;

  fpp_fw_model host_u (.core_clk, .sfr_wr, .sfr_addr, .sfr_wdata, .movx_wr, .movx_addr,
    .movx_data, .key_ok, .dbg_wr, .dbg_erase, .debug_full_device_erase);
  fpp_protect #(.OP_CYCLES(16'h0002)) dut_u (.core_clk, .nrst, .sfr_wr, .sfr_addr,
    .sfr_wdata, .sfr_rdata, .movx_wr, .movx_addr, .movx_data, .exec_addr, .key_ok,
    .vmon_en, .vmon_rst_en, .dbg_wr, .dbg_erase, .debug_full_device_erase,
    .dbg_addr(movx_addr), .dbg_data(movx_data), .lock_byte_nv, .irq_req, .irq_hold,
    .fl_write, .fl_page_erase, .fl_mass_erase, .fl_addr, .fl_data, .xram_wr,
    .flash_error_device_reset(err_rst), .flash_fault_reset_flag(fault));

  always #4 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic rst();
    @(posedge core_clk);
    sys_nrst <= 1'b0;
    repeat (16) @(posedge core_clk);
    sys_nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask : rst
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host_u.req(5, {7'h00, a}, 8'h00);
    #1;
    chk(sfr_rdata, exp);
  endtask : rd
  // One request, every answer gathered over a short window, then idle past the busy time
  task automatic op(input int kind, input logic [14:0] a, input logic [7:0] d,
                    input logic [5:0] exp);
    logic [5:0] ev;
    ev = '0;
    host_u.req(kind, a, d);
    repeat (4) begin
      #1;
      ev |= {irq_hold, err_rst, fl_mass_erase, fl_page_erase, fl_write, xram_wr};
      if (fl_write === 1'b1 || fl_page_erase === 1'b1) begin
        chk({fl_addr, fl_data}, {a, d});
      end
      @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
    chk(ev, exp);
  endtask : op
  ////////////////////////////////////////////////////////////////////////////////
  // Reset value, writable bits, an unmapped address
  task automatic s_regs();
    chk(fault, 1'b0);
    rd(8'h8f, 8'h00);
    host_u.req(0, 15'h008f, 8'hff);
    rd(8'h8f, 8'h03);
    rd(8'h90, 8'h00);
  endtask : s_regs
  // MOVX routing by the two enables; interrupts held while the engine is busy
  task automatic s_route();
    host_u.req(0, 15'h008f, 8'h00);
    op(1, 15'h0123, 8'h5a, 6'h01);
    host_u.req(0, 15'h008f, 8'h02);
    op(1, 15'h0123, 8'h5a, 6'h01);
    host_u.req(0, 15'h008f, 8'h01);
    irq_req <= 1'b1; // Masked in the core, so it only pends
    op(1, 15'h0123, 8'h5a, 6'h22);
    chk(irq_hold, 1'b0);
    irq_req <= 1'b0;
    host_u.req(0, 15'h008f, 8'h03);
    op(1, 15'h0345, 8'h00, 6'h04);
  endtask : s_route
  // Either supply monitor switch off turns a flash write into an error reset
  task automatic s_vmon();
    for (int i = 0; i < 2; i++) begin
      host_u.req(0, 15'h008f, 8'h01);
      {vmon_rst_en, vmon_en} <= 2'(1 << i);
      op(1, 15'h0200, 8'h11, 6'h10);
      chk(fault, 1'b1);
      {vmon_rst_en, vmon_en} <= 2'b11;
    end
  endtask : s_vmon
  // Page 0 locked: lock page follows, debug access dropped, mass erase allowed
  task automatic s_lock();
    lock_byte_nv <= 8'hfe;
    rst();
    host_u.req(0, 15'h008f, 8'h01);
    op(1, 15'h0010, 8'h22, 6'h10);
    host_u.req(0, 15'h008f, 8'h01);
    op(1, 15'h0200, 8'h22, 6'h02);
    op(1, 15'h7c00, 8'h22, 6'h10);
    exec_addr <= 15'h0000;
    host_u.req(0, 15'h008f, 8'h01);
    op(1, 15'h0010, 8'h22, 6'h02);
    op(1, 15'h7dff, 8'h00, 6'h10);
    for (int k = 2; k < 4; k++) op(k, 15'h0010, 8'h33, 6'h00);
    op(4, 15'h0000, 8'h00, 6'h08);
    op(2, 15'h0010, 8'h33, 6'h02);
    lock_byte_nv <= 8'hff;
    exec_addr <= 15'h1000;
  endtask : s_lock
  // A lock byte written by firmware only bites after the next reset
  task automatic s_defer();
    rst();
    host_u.req(0, 15'h008f, 8'h01);
    op(1, 15'h7dff, 8'hfe, 6'h02);
    lock_byte_nv <= 8'hfe;
    op(1, 15'h0010, 8'h44, 6'h02);
    rst();
    host_u.req(0, 15'h008f, 8'h01);
    op(1, 15'h0010, 8'h44, 6'h10);
  endtask : s_defer
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst();
    s_regs();
    s_route();
    s_vmon();
    s_lock();
    s_defer();
    finish_test();
  end
  // Cuts a hang short
  initial begin
    #400000;
    n_fail++;
    finish_test();
  end
endmodule : flash_program_protection_tb_top
`default_nettype wire
